// ### hdl/nv_window_consts.vh
// constants for the eeprom and sram register window block
`ifndef NV_WINDOW_CONSTS_VH
`define NV_WINDOW_CONSTS_VH
// ==========================================================
// register offsets
`define NVW_OFF_CONTROL 8'h31
`define NVW_OFF_LIVE_CRC 8'h32
`define NVW_OFF_START_ADDR 8'h33
`define NVW_OFF_EE_WINDOW 8'h34
`define NVW_OFF_SRAM_WINDOW 8'h35
`define NVW_OFF_UNLOCK 8'h38
// ==========================================================
// fields
`define NVW_START_ADDR_MSB 6
`define NVW_ARRAY_ADDR_MSB 4
`define NVW_CTL_PROG_BIT 0
`define NVW_CTL_ERASE_BIT 1
// ==========================================================
// values
`define NVW_UNLOCK_KEY 8'hBE
`define NVW_RST_LIVE_CRC 8'h00
`define NVW_RST_START_ADDR 7'h00
`define NVW_RST_UNLOCK 8'h00
`define NVW_RST_REG_PTR 8'h00
`define NVW_READ_ZERO 8'h00
`endif

// ### hdl/nv_window_access.v
// register-window access to the eeprom and its sram shadow array
// Behaviour
// R1: live crc byte is read-only, resets to zero, follows the crc engine.
// R2: start-address register holds a 7-bit field, top bit reads zero.
// R3: an internal pointer advances; the start register keeps its value.
// R4: array byte address uses only the low five start-address bits.
// R5: first eeprom window read of a transaction returns byte at start.
// R6: each further eeprom window read advances pointer and returns next.
// R7: after first eeprom window access the register address stays put.
// R8: eeprom window session and lock end with the transaction.
// R9: first sram window read of a transaction returns byte at start.
// R10: first sram window write of a transaction stores byte at start.
// R11: each further sram read or write steps to the next sram location.
// R12: sram window locks the register address until transaction end.
// R13: unlock must be written in the transaction before the start bit.
// R14: only the key 0xBE unlocks; the unlock register resets to zero.
// R15: program start fires only after a key-write transaction.
// R16: erase start gated alike; both bits together mean erase+program.
// R17: the five-bit array pointer wraps from the top back to zero.
`default_nettype none
`include "nv_window_consts.vh"

// ==========================================================
// read data buffer
module nv_byte_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   input wire clk,
   input wire reset,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_ff;
   reg [AW:0] rd_ff;
   wire full;
   wire empty;
   assign empty = (wr_ff == rd_ff);
   assign full = (wr_ff[AW-1:0] == rd_ff[AW-1:0]) &&
                 (wr_ff[AW] != rd_ff[AW]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rd_ff[AW-1:0]];
   always @(posedge clk) begin
      if (in_valid && !full) begin
         mem[wr_ff[AW-1:0]] <= in_data;
      end
   end
   always @(posedge clk) begin
      if (reset) begin
         wr_ff <= {(AW+1){1'b0}};
         rd_ff <= {(AW+1){1'b0}};
      end else begin
         if (in_valid && !full) begin
            wr_ff <= wr_ff + {{AW{1'b0}}, 1'b1};
         end
         if (out_ready && !empty) begin
            rd_ff <= rd_ff + {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule

// ==========================================================
// window access top
module nv_window_access #(
   parameter FIFO_DEPTH = 32,
   parameter FIFO_AW = 5,
   parameter ARRAY_BYTES = 32
) (
   input wire clk,
   input wire reset,
   input wire reg_addr_valid,
   input wire [7:0] reg_addr_in,
   input wire wr_valid,
   input wire [7:0] wr_data,
   input wire rd_req,
   output wire rd_req_ready,
   output wire rd_valid,
   input wire rd_ready,
   output wire [7:0] rd_data,
   input wire txn_end,
   input wire [7:0] crc_live_in,
   output reg [4:0] ee_rd_addr_ff,
   input wire [7:0] ee_rd_data,
   input wire [4:0] eng_sram_addr,
   output reg [7:0] eng_sram_data_ff,
   output reg erase_start_ff,
   output reg program_start_ff,
   output reg [7:0] reg_ptr_ff
);
   // ==========================================================
   // state
   reg [7:0] live_crc_ff;
   reg [6:0] start_addr_ff;
   reg [7:0] unlock_ff;
   reg [4:0] ee_ptr_ff;
   reg [4:0] ram_ptr_ff;
   reg ee_sess_ff;
   reg ram_sess_ff;
   reg key_seen_ff;
   reg armed_ff;
   reg pend_ff;
   reg [1:0] pend_src_ff;
   reg [4:0] pend_ram_ff;
   reg [7:0] pend_reg_ff;
   reg [7:0] sram [0:ARRAY_BYTES-1];
   reg [7:0] nxt_reg_ptr;
   reg [4:0] nxt_ee_ptr;
   reg [4:0] nxt_ram_ptr;
   reg nxt_ee_sess;
   reg nxt_ram_sess;
   reg [4:0] acc_addr;
   reg [7:0] reg_value;
   reg [7:0] push_data;
   wire fifo_in_ready;
   wire rd_take;
   wire access;
   wire on_ee;
   wire on_ram;

   localparam SRC_REG = 2'h0;
   localparam SRC_EE = 2'h1;
   localparam SRC_RAM = 2'h2;

   // array address: session start from low start bits, else step on
   function [4:0] array_addr;
      input sess;
      input [6:0] start;
      input [4:0] ptr;
      begin
         if (sess) begin
            array_addr = ptr + 5'h01; // [R6] [R11] [R17]
         end else begin
            array_addr = start[`NVW_ARRAY_ADDR_MSB:0]; // [R4] [R5] [R9]
         end
      end
   endfunction

   // one read in flight keeps the buffer from overrunning
   assign rd_req_ready = fifo_in_ready && !pend_ff;
   assign rd_take = rd_req && rd_req_ready;
   assign access = rd_take || wr_valid;
   assign on_ee = (reg_ptr_ff == `NVW_OFF_EE_WINDOW);
   assign on_ram = (reg_ptr_ff == `NVW_OFF_SRAM_WINDOW);

   // ==========================================================
   // register read mux
   always @* begin
      case (reg_ptr_ff)
         `NVW_OFF_LIVE_CRC: reg_value = live_crc_ff; // [R1]
         `NVW_OFF_START_ADDR: reg_value = {1'b0, start_addr_ff}; // [R2] [R3]
         `NVW_OFF_UNLOCK: reg_value = unlock_ff;
         default: reg_value = `NVW_READ_ZERO;
      endcase
   end

   // ==========================================================
   // pointer and session next state
   always @* begin
      nxt_reg_ptr = reg_ptr_ff;
      nxt_ee_ptr = ee_ptr_ff;
      nxt_ram_ptr = ram_ptr_ff;
      nxt_ee_sess = ee_sess_ff;
      nxt_ram_sess = ram_sess_ff;
      acc_addr = 5'h00;
      if (reg_addr_valid) begin
         nxt_reg_ptr = reg_addr_in;
      end else if (access) begin
         if (on_ee) begin
            // writes to the read-only window still lock the address
            acc_addr = array_addr(ee_sess_ff, start_addr_ff, ee_ptr_ff);
            nxt_ee_ptr = acc_addr; // [R3] [R6]
            nxt_ee_sess = 1'b1; // [R7]
         end else if (on_ram) begin
            acc_addr = array_addr(ram_sess_ff, start_addr_ff, ram_ptr_ff);
            nxt_ram_ptr = acc_addr; // [R11]
            nxt_ram_sess = 1'b1; // [R12]
         end else begin
            nxt_reg_ptr = reg_ptr_ff + 8'h01;
         end
      end
      if (txn_end) begin
         nxt_ee_sess = 1'b0; // [R8]
         nxt_ram_sess = 1'b0; // [R12]
      end
   end

   always @* begin
      case (pend_src_ff)
         SRC_EE: push_data = ee_rd_data;
         SRC_RAM: push_data = sram[pend_ram_ff];
         default: push_data = pend_reg_ff;
      endcase
   end

   // ==========================================================
   // sequential state
   always @(posedge clk) begin
      if (reset) begin
         reg_ptr_ff <= `NVW_RST_REG_PTR;
         live_crc_ff <= `NVW_RST_LIVE_CRC; // [R1]
         start_addr_ff <= `NVW_RST_START_ADDR; // [R2]
         unlock_ff <= `NVW_RST_UNLOCK; // [R14]
         ee_ptr_ff <= 5'h00;
         ram_ptr_ff <= 5'h00;
         ee_sess_ff <= 1'b0;
         ram_sess_ff <= 1'b0;
         key_seen_ff <= 1'b0;
         armed_ff <= 1'b0;
         pend_ff <= 1'b0;
         pend_src_ff <= SRC_REG;
         pend_ram_ff <= 5'h00;
         pend_reg_ff <= `NVW_READ_ZERO;
         ee_rd_addr_ff <= 5'h00;
         eng_sram_data_ff <= 8'h00;
         erase_start_ff <= 1'b0;
         program_start_ff <= 1'b0;
      end else begin
         // crc value comes from the engine, never from the array
         live_crc_ff <= crc_live_in; // [R1]
         reg_ptr_ff <= nxt_reg_ptr;
         ee_ptr_ff <= nxt_ee_ptr;
         ram_ptr_ff <= nxt_ram_ptr;
         ee_sess_ff <= nxt_ee_sess;
         ram_sess_ff <= nxt_ram_sess;
         eng_sram_data_ff <= sram[eng_sram_addr];
         erase_start_ff <= 1'b0;
         program_start_ff <= 1'b0;
         pend_ff <= rd_take && !reg_addr_valid;
         if (rd_take && !reg_addr_valid) begin
            pend_reg_ff <= reg_value;
            pend_ram_ff <= acc_addr;
            if (on_ee) begin
               pend_src_ff <= SRC_EE;
               ee_rd_addr_ff <= acc_addr; // [R5] [R6]
            end else if (on_ram) begin
               pend_src_ff <= SRC_RAM; // [R9] [R11]
            end else begin
               pend_src_ff <= SRC_REG;
            end
         end
         if (wr_valid && !reg_addr_valid) begin
            case (reg_ptr_ff)
               `NVW_OFF_START_ADDR: begin
                  start_addr_ff <= wr_data[`NVW_START_ADDR_MSB:0]; // [R2]
               end
               `NVW_OFF_UNLOCK: begin
                  unlock_ff <= wr_data;
               end
               `NVW_OFF_CONTROL: begin
                  // self-clearing starts, gated by the prior transaction
                  if (armed_ff) begin
                     erase_start_ff <= wr_data[`NVW_CTL_ERASE_BIT]; // [R16]
                     program_start_ff <= wr_data[`NVW_CTL_PROG_BIT]; // [R15]
                  end
               end
               default: begin
               end
            endcase
         end
         // key must land in the transaction just before the start bit
         if (txn_end) begin
            armed_ff <= key_seen_ff ||
                        (wr_valid && !reg_addr_valid &&
                         reg_ptr_ff == `NVW_OFF_UNLOCK &&
                         wr_data == `NVW_UNLOCK_KEY); // [R13] [R14]
            key_seen_ff <= 1'b0;
         end else if (wr_valid && !reg_addr_valid &&
                      reg_ptr_ff == `NVW_OFF_UNLOCK) begin
            key_seen_ff <= (wr_data == `NVW_UNLOCK_KEY); // [R14]
         end else if (access && !reg_addr_valid) begin
            key_seen_ff <= 1'b0; // [R13]
         end
      end
   end

   // ==========================================================
   // sram array write port
   always @(posedge clk) begin
      if (wr_valid && !reg_addr_valid && on_ram) begin
         sram[acc_addr] <= wr_data; // [R10] [R11]
      end
   end

   nv_byte_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_rd_fifo (
      .clk(clk),
      .reset(reset),
      .in_valid(pend_ff),
      .in_ready(fifo_in_ready),
      .in_data(push_data),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_data)
   );
endmodule
`default_nettype wire

// ### verif/ee_array_model.sv
// eeprom array model: asynchronous byte read from a 5-bit address
`default_nettype none
module ee_array_model (
   input wire logic [4:0] addr,
   output logic [7:0] data
);
   timeunit 1ns;
   timeprecision 1ns;
   // distinct byte in every location so a wrong step or wrap shows
   assign data = {~addr[2:0], addr};
endmodule
`default_nettype wire

// ### verif/nv_window_assertions.sv
// assertion checker for the eeprom and sram window block
`default_nettype none
module nv_window_checker (
   input wire logic clk,
   input wire logic reset,
   input wire logic reg_addr_valid,
   input wire logic wr_valid,
   input wire logic [7:0] wr_data,
   input wire logic rd_req,
   input wire logic rd_req_ready,
   input wire logic rd_valid,
   input wire logic rd_ready,
   input wire logic erase_start_ff,
   input wire logic program_start_ff,
   input wire logic [7:0] reg_ptr_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // =====
   // accepted accesses; the address byte wins over data
   wire logic rd_go = rd_req && rd_req_ready && !reg_addr_valid;
   wire logic wr_go = wr_valid && !reg_addr_valid;
   wire logic ctl_wr = wr_go && reg_ptr_ff == 8'h31;
   wire logic on_win = reg_ptr_ff == 8'h34 || reg_ptr_ff == 8'h35;
   property p_prog_pulse; program_start_ff |=> !program_start_ff; endproperty
   a_prog_pulse: assert property (p_prog_pulse)
      else $error("program start longer than one cycle");
   property p_erase_pulse; erase_start_ff |=> !erase_start_ff; endproperty
   a_erase_pulse: assert property (p_erase_pulse)
      else $error("erase start longer than one cycle");
   property p_prog_cause;
      program_start_ff |-> $past(ctl_wr) && $past(wr_data[0]);
   endproperty
   a_prog_cause: assert property (p_prog_cause)
      else $error("program start without control write");
   property p_erase_cause;
      erase_start_ff |-> $past(ctl_wr) && $past(wr_data[1]);
   endproperty
   a_erase_cause: assert property (p_erase_cause)
      else $error("erase start without control write");
   property p_ee_lock;
      (rd_go || wr_go) && reg_ptr_ff == 8'h34 |=> reg_ptr_ff == 8'h34;
   endproperty
   a_ee_lock: assert property (p_ee_lock)
      else $error("pointer left eeprom window");
   property p_sram_lock;
      (rd_go || wr_go) && reg_ptr_ff == 8'h35 |=> reg_ptr_ff == 8'h35;
   endproperty
   a_sram_lock: assert property (p_sram_lock)
      else $error("pointer left sram window");
   property p_ptr_inc;
      (rd_go || wr_go) && !on_win |=> reg_ptr_ff == $past(reg_ptr_ff) + 8'h01;
   endproperty
   a_ptr_inc: assert property (p_ptr_inc)
      else $error("register pointer did not step");
   property p_rd_lat; rd_go && !rd_valid |-> ##[1:2] rd_valid; endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("read byte late");
   c_both: cover property (program_start_ff && erase_start_ff);
   c_full: cover property (!rd_req_ready && rd_valid);
   c_pop: cover property (rd_valid && rd_ready);
endmodule
bind nv_window_access nv_window_checker chk (.clk(clk), .reset(reset),
   .reg_addr_valid(reg_addr_valid), .wr_valid(wr_valid), .wr_data(wr_data),
   .rd_req(rd_req), .rd_req_ready(rd_req_ready), .rd_valid(rd_valid),
   .rd_ready(rd_ready), .erase_start_ff(erase_start_ff),
   .program_start_ff(program_start_ff), .reg_ptr_ff(reg_ptr_ff));
`default_nettype wire

// ### verif/nv_window_access_bench.sv
// self-checking bench for the eeprom and sram window block
`default_nettype none
module nv_window_access_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [3:0] ka = 4'h1, kw = 4'h2, kr = 4'h4, kt = 4'h8;
   logic clk = 0, reset = 1, rav = 0, wv = 0, rq = 0, rr = 0, te = 0;
   logic rqr, rv, es, ps;
   logic [7:0] ra = 8'h00, wd = 8'h00, rdat, ptr, eng, ed;
   logic [4:0] ea, esa = 5'h00;
   logic [7:0] crc = 8'hC7;
   integer failures = 0, n_checks = 0;
   nv_window_access uut (.clk(clk), .reset(reset), .reg_addr_valid(rav),
      .reg_addr_in(ra), .wr_valid(wv), .wr_data(wd), .rd_req(rq),
      .rd_req_ready(rqr), .rd_valid(rv), .rd_ready(rr), .rd_data(rdat),
      .txn_end(te), .crc_live_in(crc), .ee_rd_addr_ff(ea),
      .ee_rd_data(ed), .eng_sram_addr(esa), .eng_sram_data_ff(eng),
      .erase_start_ff(es), .program_start_ff(ps), .reg_ptr_ff(ptr));
   ee_array_model ee (.addr(ea), .data(ed));
   initial forever #50 clk = ~clk;
   // =====
   // tasks
   task stop_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one strobe per call; the idle edge between calls keeps reads apart
   task put(input logic [3:0] k, input logic [7:0] d);
      @(posedge clk);
      {te, rq, wv, rav} <= k;
      ra <= d;
      wd <= d;
      @(posedge clk);
      {te, rq, wv, rav} <= 4'h0;
   endtask
   task pop(input logic [7:0] e);
      integer i;
      i = 0;
      @(negedge clk);
      while (rv !== 1'b1 && i < 8) begin
         i++;
         @(negedge clk);
      end
      chk(rv === 1'b1 ? rdat : 8'hXX, e);
      @(posedge clk);
      rr <= 1;
      @(posedge clk);
      rr <= 0;
   endtask
   task rp(input logic [7:0] e);
      put(kr, 8'h00);
      pop(e);
   endtask
   function automatic logic [7:0] ee_exp(input logic [4:0] a);
      return {~a[2:0], a};
   endfunction
   // control write, then watch both start pulses for a few cycles
   task strt(input logic [7:0] d, input logic [1:0] e);
      logic [1:0] s;
      s = 2'b00;
      put(ka, 8'h31);
      put(kw, d);
      repeat (3) begin
         @(negedge clk);
         s = s | {es, ps};
      end
      chk({6'h00, s}, {6'h00, e});
      put(kt, 8'h00);
   endtask
   // =====
   // tests
   task t_regs;
      put(ka, 8'h33);
      put(kw, 8'hFE);
      put(kt, 8'h00);
      put(ka, 8'h32);
      rp(8'hC7);
      rp(8'h7E);
      rp(ee_exp(5'h1E));
      rp(ee_exp(5'h1F));
      rp(ee_exp(5'h00));
      chk(ptr, 8'h34);
      put(kt, 8'h00);
      put(ka, 8'h33);
      rp(8'h7E);
      put(kt, 8'h00);
      $display("test regs done");
   endtask
   task t_sram;
      esa <= 5'h1F;
      put(ka, 8'h35);
      put(kw, 8'hA1);
      put(kw, 8'hB2);
      put(kw, 8'hC3);
      chk(ptr, 8'h35);
      put(kt, 8'h00);
      put(ka, 8'h35);
      rp(8'hA1);
      rp(8'hB2);
      rp(8'hC3);
      put(kt, 8'h00);
      chk(eng, 8'hB2);
      $display("test sram done");
   endtask
   task t_fifo;
      integer i;
      put(ka, 8'h34);
      for (i = 0; i < 32; i++)
         put(kr, 8'h00);
      repeat (2) @(negedge clk);
      chk({7'h00, rqr}, 8'h00);
      for (i = 0; i < 32; i++)
         pop(ee_exp(5'h1E + i[4:0]));
      put(kt, 8'h00);
      $display("test fifo done");
   endtask
   task t_unlock;
      put(ka, 8'h38);
      put(kw, 8'hBE);
      put(kt, 8'h00);
      strt(8'h03, 2'b11);
      put(ka, 8'h38);
      put(kw, 8'hBD);
      put(kt, 8'h00);
      strt(8'h01, 2'b00);
      put(ka, 8'h38);
      put(kw, 8'hBE);
      put(kt, 8'h00);
      put(ka, 8'h38);
      rp(8'hBE);
      put(kt, 8'h00);
      strt(8'h02, 2'b00);
      $display("test unlock done");
   endtask
   // mid-run reset must drop the key, start address and unlock byte
   task t_reset;
      put(ka, 8'h33);
      put(kw, 8'h55);
      put(kt, 8'h00);
      put(ka, 8'h38);
      put(kw, 8'hBE);
      put(kt, 8'h00);
      @(posedge clk);
      reset <= 1;
      crc <= 8'h5A;
      repeat (3) @(posedge clk);
      reset <= 0;
      strt(8'h03, 2'b00);
      put(ka, 8'h32);
      put(kw, 8'h11);
      put(ka, 8'h32);
      rp(8'h5A);
      rp(8'h00);
      put(ka, 8'h38);
      rp(8'h00);
      put(kt, 8'h00);
      $display("test reset done");
   endtask
   initial begin
      repeat (3) @(posedge clk);
      reset <= 0;
      t_regs;
      t_sram;
      t_fifo;
      t_unlock;
      t_reset;
      stop_test;
   end
   // whole run is well under two thousand cycles
   initial begin
      #300000;
      failures++;
      stop_test;
   end
endmodule
`default_nettype wire
